// ===== inc/pipe_ctrl_regs.vh
// Constants for the pipeline sequencing and interlock control
`ifndef PIPE_CTRL_REGS_VH
`define PIPE_CTRL_REGS_VH

// Fixed handler address for every entry to debug mode
`define DBG_HANDLER_ADDR   32'h0000_0060
// Exception code of the debug-trap instruction
`define DBG_TRAP_CODE      16'h0060
// Software trap codes: upper twelve bits 004x or 005x
`define SW_TRAP_HI_A       12'h004
`define SW_TRAP_HI_B       12'h005
// Instruction classes handed over by the decoder
`define CLS_ALU            4'h0
`define CLS_LOAD           4'h1
`define CLS_HALFWORD_MULTIPLY_INSTR           4'h2
`define CLS_SYSW           4'h3
`define CLS_SYSR           4'h4
`define CLS_TRAP           4'h5
`define CLS_DEBUG_TRAP_INSTR         4'h6
`define CLS_DEBUG_RETURN_INSTR          4'h7
`define CLS_BRANCH         4'h8
`define CLS_INVALID        4'h9
`define CLS_OTHER          4'ha
// System register numbers of the two exception save registers
`define SREG_IRQ_PC        5'h00
`define SREG_FATAL_PC      5'h02
// Extra decode clocks added by each interlock
`define STALL_LOAD         2'h1
`define STALL_HALFWORD_MULTIPLY_INSTR         2'h1
`define STALL_SYSREG       2'h2
// Extra clocks of an alignment refetch (branch takes 4 instead of 2)
`define STALL_ALIGN        2'h2
// Forwarding source selects
`define FWD_RF             2'h0
`define FWD_EX             2'h1
`define FWD_MEM            2'h2
`define FWD_EX2            2'h3
// Sequencer states
`define ST_RUN             2'h0
`define ST_ID1             2'h1
`define ST_ID2             2'h2
// Debug register groups
`define DSEL_ADDRESS_SPACE_ID_REG          2'h0
`define DSEL_DIR           2'h1
`define DSEL_BREAK         2'h2

`endif

// ===== src/interlock_check.v
// Operand dependency check between decode and the incoming instruction
`timescale 1ns/10ps
`include "pipe_ctrl_regs.vh"

module interlock_check (
  input  wire       prev_valid,   // Older instruction present in decode
  input  wire [3:0] prev_cls,     // Its class
  input  wire [4:0] prev_dst,     // Its destination register
  input  wire [4:0] prev_sreg,    // Its system register number
  input  wire [3:0] new_cls,      // Incoming instruction class
  input  wire [4:0] new_src1,     // Incoming first source
  input  wire [4:0] new_src2,     // Incoming second source
  input  wire [4:0] new_sreg,     // Incoming system register number
  output reg  [1:0] stall_cyc,    // Extra decode clocks needed
  output reg  [1:0] fwd1,         // Forward select, first source
  output reg  [1:0] fwd2          // Forward select, second source
);

  wire hit1;   // First source matches older destination
  wire hit2;   // Second source matches older destination
  wire save_reg;  // Older write targets an exception save register

  // Register zero never carries a result, so it never interlocks
  assign hit1     = prev_valid && (prev_dst != 5'h00) && (new_src1 == prev_dst);
  assign hit2     = prev_valid && (prev_dst != 5'h00) && (new_src2 == prev_dst);
  assign save_reg = (prev_sreg == `SREG_IRQ_PC) || (prev_sreg == `SREG_FATAL_PC);

  // Dependency compare and forward choice
  always @* begin
    stall_cyc = 2'h0;
    fwd1      = `FWD_RF;
    fwd2      = `FWD_RF;
    case (prev_cls)
      `CLS_ALU: begin
        fwd1 = hit1 ? `FWD_EX : `FWD_RF;
        fwd2 = hit2 ? `FWD_EX : `FWD_RF;
      end
      `CLS_LOAD: begin
        if (hit1 || hit2) begin
          stall_cyc = `STALL_LOAD;
        end
        fwd1 = hit1 ? `FWD_MEM : `FWD_RF;
        fwd2 = hit2 ? `FWD_MEM : `FWD_RF;
      end
      `CLS_HALFWORD_MULTIPLY_INSTR: begin
        if (hit1 || hit2) begin
          stall_cyc = `STALL_HALFWORD_MULTIPLY_INSTR;
        end
        fwd1 = hit1 ? `FWD_EX2 : `FWD_RF;
        fwd2 = hit2 ? `FWD_EX2 : `FWD_RF;
      end
      `CLS_SYSW: begin
        if ((new_cls == `CLS_SYSR) && save_reg && (new_sreg == prev_sreg)) begin
          stall_cyc = `STALL_SYSREG;
        end
      end
      // No result worth forwarding
      default: begin
        stall_cyc = 2'h0;
      end
    endcase
  end

endmodule // interlock_check

// ===== src/pipe_hazard_ctrl.v
// Pipeline sequencing, interlocks, forwarding and debug-mode entry
`timescale 1ns/10ps
`include "pipe_ctrl_regs.vh"

module pipe_hazard_ctrl (
  input  wire        mclk,              // Core clock, 50 MHz
  input  wire        reset_n,           // Asynchronous reset, active low
  input  wire        clk_en,            // Freezes all state while low
  input  wire        if_valid,          // Fetched instruction offered
  input  wire [3:0]  if_cls,            // Its decoded class
  input  wire [4:0]  if_src1,           // First source register
  input  wire [4:0]  if_src2,           // Second source register
  input  wire [4:0]  if_dst,            // Destination register
  input  wire [4:0]  if_sreg,           // System register number
  input  wire [15:0] if_code,           // Exception code field
  input  wire        if_len4,           // Instruction is four bytes
  input  wire        if_mem_access,     // Instruction uses the data path
  input  wire        id_br_taken,       // Branch in decode is taken
  input  wire [31:0] id_br_target,      // Its target address
  input  wire [31:0] debug_pc_save_reg, // Debug PC save register value
  input  wire        single_step_cfg,   // Single-step operation set
  input  wire        debug_break,       // Break condition matched
  input  wire        dreg_req,          // Debug register access request
  input  wire        dreg_write,        // Access is a write
  input  wire [1:0]  dreg_sel,          // Register group accessed
  output reg         fetch_en_q,        // Fetch may proceed this clock
  output reg         fetch_discard_q,   // Fetch in flight is thrown away
  output reg         align_refetch_q,   // Second fetch of misaligned target
  output reg         id_stall_q,        // Decode held by an interlock
  output reg         id_phase2_q,       // Second decode clock
  output reg  [1:0]  fwd_src1_q,        // Forward select, first source
  output reg  [1:0]  fwd_src2_q,        // Forward select, second source
  output reg         dmem_req_q,        // Memory stage data access
  output reg         redirect_q,        // Load PC with redirect_pc_q
  output reg  [31:0] redirect_pc_q,     // New program counter
  output reg         debug_mode_q,      // Core is in debug mode
  output reg         dcache_freeze_q,   // Data cache must not update
  output reg         dreg_grant_q,      // Debug register access taken
  output reg         dreg_deny_q        // Debug register access refused
);

  // Decode stage contents
  reg        id_valid_q;
  reg [3:0]  id_cls_q;
  reg [4:0]  id_dst_q;
  reg [4:0]  id_sreg_q;
  reg [15:0] id_code_q;
  reg        id_mem_q;
  // Execute and memory stage tracking
  reg        ex_valid_q;
  reg        ex_mem_q;
  reg        mem_mem_q;
  // Sequencer and stall counters
  reg [1:0]  state_q;
  reg [1:0]  stall_cnt_q;     // Interlock clocks still to insert
  reg [1:0]  align_cnt_q;     // Refetch clocks still to insert
  reg        align_arm_q;     // First fetch after a redirect pending
  reg [31:0] handler_q;       // Address formed in the first decode clock
  reg        trap_hit_q;      // First decode clock found a valid code

  wire [1:0] chk_stall;       // Extra decode clocks for incoming one
  wire [1:0] chk_fwd1;
  wire [1:0] chk_fwd2;
  wire       hold;            // Decode cannot take a new instruction
  wire       take;            // Incoming instruction enters decode
  wire       two_id;          // Decode instruction needs two clocks
  wire       sw_trap_code;    // Code lies in a software trap range
  wire       enter_dbg;       // Break, single step or invalid instruction enters debug this clock
  wire       step_done;       // Instruction finished execute in step mode
  wire       align_need;      // Target is four bytes at a halfword address
  wire       hold_next;       // Decode will be held after this edge

  // Dependency comparator against the instruction now in decode
  interlock_check u_chk (
    .prev_valid (id_valid_q),
    .prev_cls   (id_cls_q),
    .prev_dst   (id_dst_q),
    .prev_sreg  (id_sreg_q),
    .new_cls    (if_cls),
    .new_src1   (if_src1),
    .new_src2   (if_src2),
    .new_sreg   (if_sreg),
    .stall_cyc  (chk_stall),
    .fwd1       (chk_fwd1),
    .fwd2       (chk_fwd2)
  );

  assign hold = (stall_cnt_q != 2'h0) || (align_cnt_q != 2'h0) || (state_q != `ST_RUN);
  assign take = if_valid && !hold;

  assign two_id = id_valid_q && ((id_cls_q == `CLS_TRAP) || (id_cls_q == `CLS_DEBUG_TRAP_INSTR) ||
                                 (id_cls_q == `CLS_DEBUG_RETURN_INSTR));

  assign sw_trap_code = (id_code_q[15:4] == `SW_TRAP_HI_A) || (id_code_q[15:4] == `SW_TRAP_HI_B);

  assign align_need = align_arm_q && if_valid && if_len4 && (if_code[1:0] == 2'h0) &&
                      (redirect_pc_q[1:0] == 2'b10);

  assign step_done = single_step_cfg && ex_valid_q && !debug_mode_q;

  // Fetch must close at the edge that starts a hold, or one word is lost
  assign hold_next = (take && ((chk_stall != 2'h0) || (if_cls == `CLS_TRAP) ||
                               (if_cls == `CLS_DEBUG_TRAP_INSTR) || (if_cls == `CLS_DEBUG_RETURN_INSTR))) ||
                     (two_id && (state_q == `ST_RUN) && !enter_dbg) || align_need;

  // Breaks, invalid instructions and single step all take the same entry
  assign enter_dbg = debug_break || step_done ||
                     (id_valid_q && (state_q == `ST_RUN) && (id_cls_q == `CLS_INVALID));

  // Decode stage register and stall counting
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      id_valid_q  <= 1'b0;
      id_cls_q    <= `CLS_OTHER;
      id_dst_q    <= 5'h00;
      id_sreg_q   <= 5'h00;
      id_code_q   <= 16'h0000;
      id_mem_q    <= 1'b0;
      stall_cnt_q <= 2'h0;
      fwd_src1_q  <= `FWD_RF;
      fwd_src2_q  <= `FWD_RF;
      id_stall_q  <= 1'b0;
    end else if (clk_en) begin
      if (enter_dbg || redirect_q) begin
        // Anything in decode is squashed by a redirect
        id_valid_q  <= 1'b0;
        stall_cnt_q <= 2'h0;
        id_stall_q  <= 1'b0;
      end else if (take) begin
        id_valid_q  <= 1'b1;
        id_cls_q    <= if_cls;
        id_dst_q    <= if_dst;
        id_sreg_q   <= if_sreg;
        id_code_q   <= if_code;
        id_mem_q    <= if_mem_access;
        stall_cnt_q <= chk_stall;
        id_stall_q  <= (chk_stall != 2'h0);
        fwd_src1_q  <= chk_fwd1;
        fwd_src2_q  <= chk_fwd2;
      end else if (stall_cnt_q != 2'h0) begin
        stall_cnt_q <= stall_cnt_q - 2'h1;
        id_stall_q  <= (stall_cnt_q != 2'h1);
      end else if (!hold) begin
        // Bubble: nothing offered by fetch
        id_valid_q  <= 1'b0;
        id_stall_q  <= 1'b0;
      end else if (state_q == `ST_ID2) begin
        // Two-clock decode done, instruction moves on
        id_valid_q  <= 1'b0;
      end
    end
  end

  // Execute and memory stage tracking
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ex_valid_q <= 1'b0;
      ex_mem_q   <= 1'b0;
      mem_mem_q  <= 1'b0;
      dmem_req_q <= 1'b0;
      fetch_en_q <= 1'b0;
    end else if (clk_en) begin
      // Leaves decode only when no stall and no second clock is due
      ex_valid_q <= id_valid_q && (stall_cnt_q == 2'h0) &&
                    (!two_id || (state_q == `ST_ID2)) && !enter_dbg;
      ex_mem_q   <= id_mem_q && id_valid_q && (stall_cnt_q == 2'h0) && !two_id;
      mem_mem_q  <= ex_mem_q;
      dmem_req_q <= ex_mem_q;
      fetch_en_q <= !hold && !hold_next;
    end
  end

  // Two-clock decode sequencer for trap, debug trap and debug return
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q         <= `ST_RUN;
      handler_q       <= `DBG_HANDLER_ADDR;
      trap_hit_q      <= 1'b0;
      id_phase2_q     <= 1'b0;
      fetch_discard_q <= 1'b0;
    end else if (clk_en) begin
      case (state_q)
        `ST_RUN: begin
          id_phase2_q     <= 1'b0;
          fetch_discard_q <= 1'b0;
          if (two_id && !enter_dbg) begin
            state_q <= `ST_ID1;
          end
        end
        `ST_ID1: begin
          state_q         <= `ST_ID2;
          id_phase2_q     <= 1'b1;
          fetch_discard_q <= 1'b1;
          trap_hit_q      <= sw_trap_code;
          if (id_cls_q == `CLS_DEBUG_TRAP_INSTR) begin
            trap_hit_q <= (id_code_q == `DBG_TRAP_CODE);
          end
          handler_q       <= {16'h0000, id_code_q[15:4], 4'h0};
        end
        `ST_ID2: begin
          // Second fetch after the instruction also dropped
          state_q         <= `ST_RUN;
          id_phase2_q     <= 1'b0;
          fetch_discard_q <= 1'b1;
        end
        default: begin
          state_q <= `ST_RUN;
        end
      endcase
    end
  end

  // Redirects, debug mode and alignment refetch
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      redirect_q      <= 1'b0;
      redirect_pc_q   <= 32'h0000_0000;
      debug_mode_q    <= 1'b0;
      dcache_freeze_q <= 1'b0;
      align_cnt_q     <= 2'h0;
      align_arm_q     <= 1'b0;
      align_refetch_q <= 1'b0;
    end else if (clk_en) begin
      redirect_q      <= 1'b0;
      align_refetch_q <= 1'b0;
      if (enter_dbg || ((state_q == `ST_ID2) && (id_cls_q == `CLS_DEBUG_TRAP_INSTR))) begin
        redirect_q      <= 1'b1;
        redirect_pc_q   <= `DBG_HANDLER_ADDR;
        debug_mode_q    <= 1'b1;
        dcache_freeze_q <= 1'b1;
        align_arm_q     <= 1'b0;
      end else if ((state_q == `ST_ID2) && (id_cls_q == `CLS_DEBUG_RETURN_INSTR)) begin
        redirect_q      <= 1'b1;
        redirect_pc_q   <= debug_pc_save_reg;
        debug_mode_q    <= 1'b0;
        dcache_freeze_q <= 1'b0;
        align_arm_q     <= 1'b1;
      end else if ((state_q == `ST_ID2) && (id_cls_q == `CLS_TRAP)) begin
        // handler formed in ID1; bad code traps to debug
        redirect_q      <= 1'b1;
        redirect_pc_q   <= trap_hit_q ? handler_q : `DBG_HANDLER_ADDR;
        debug_mode_q    <= debug_mode_q || !trap_hit_q;
        dcache_freeze_q <= debug_mode_q || !trap_hit_q;
        align_arm_q     <= trap_hit_q;
      end else if (id_valid_q && (state_q == `ST_RUN) && (stall_cnt_q == 2'h0) &&
                   (id_cls_q == `CLS_BRANCH) && id_br_taken) begin
        // Taken branch decided in decode
        redirect_q      <= 1'b1;
        redirect_pc_q   <= id_br_target;
        align_arm_q     <= 1'b1;
      end else if (align_need) begin
        // two extra clocks
        // Fetch closes at this edge, so one counted clock completes the pair
        align_cnt_q     <= `STALL_ALIGN - 2'h1;
        align_arm_q     <= 1'b0;
      end else if (align_cnt_q != 2'h0) begin
        align_cnt_q     <= align_cnt_q - 2'h1;
        align_refetch_q <= 1'b1;
      end else if (if_valid) begin
        align_arm_q     <= 1'b0;
      end
    end
  end

  // Debug register access policy
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dreg_grant_q <= 1'b0;
      dreg_deny_q  <= 1'b0;
    end else if (clk_en) begin
      if (dreg_req) begin
        if ((dreg_sel == `DSEL_ADDRESS_SPACE_ID_REG) || debug_mode_q || ((dreg_sel == `DSEL_DIR) && !dreg_write)) begin
          dreg_grant_q <= 1'b1;
          dreg_deny_q  <= 1'b0;
        end else begin
          dreg_grant_q <= 1'b0;
          dreg_deny_q  <= 1'b1;
        end
      end else begin
        dreg_grant_q <= 1'b0;
        dreg_deny_q  <= 1'b0;
      end
    end
  end

endmodule // pipe_hazard_ctrl

// ===== tb/pipe_hazard_ctrl_asserts.sv
// Concurrent checks on the pipeline control ports
`timescale 1ns/10ps
`include "pipe_ctrl_regs.vh"
module pipe_ctrl_checker (
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic        clk_en,
  input wire logic        debug_break,
  input wire logic        dreg_req,
  input wire logic [1:0]  dreg_sel,
  input wire logic        fetch_en_q,
  input wire logic        fetch_discard_q,
  input wire logic        align_refetch_q,
  input wire logic        id_stall_q,
  input wire logic        id_phase2_q,
  input wire logic        redirect_q,
  input wire logic [31:0] redirect_pc_q,
  input wire logic        debug_mode_q,
  input wire logic        dcache_freeze_q,
  input wire logic        dreg_grant_q,
  input wire logic        dreg_deny_q
);
  // One core clock, async reset quiets every check
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Two dropped fetches, then fetch resumes
  sequence two_drop_s; fetch_discard_q [*2] ##1 !fetch_discard_q; endsequence
  // Second decode clock hands over to the redirect
  sequence hand_off_s; redirect_q && !id_phase2_q; endsequence
  drop_two_a: assert property ($rose(fetch_discard_q) |-> two_drop_s)
    else $error("discard not two cycles");
  phase_redirect_a: assert property (id_phase2_q && clk_en |=> hand_off_s)
    else $error("no redirect after second decode");
  entry_pc_a: assert property ($rose(debug_mode_q) |-> redirect_q && redirect_pc_q == `DBG_HANDLER_ADDR)
    else $error("debug entry without handler address");
  freeze_follows_a: assert property (dcache_freeze_q == debug_mode_q)
    else $error("cache freeze differs from debug mode");
  stall_holds_a: assert property (id_stall_q |-> !fetch_en_q)
    else $error("fetch open during interlock");
  stall_bound_a: assert property ($rose(id_stall_q) |-> ##[1:2] !id_stall_q)
    else $error("interlock longer than two clocks");
  break_deny_a: assert property (dreg_req && dreg_sel == `DSEL_BREAK && !debug_mode_q && clk_en
    |=> dreg_deny_q && !dreg_grant_q)
    else $error("break register reached outside debug");
  address_space_id_reg_grant_a: assert property (dreg_req && dreg_sel == `DSEL_ADDRESS_SPACE_ID_REG && clk_en |=> dreg_grant_q)
    else $error("space id access refused");
  align_once_a: assert property (align_refetch_q |=> !align_refetch_q)
    else $error("refetch pulse too long");
  break_entry_a: assert property (debug_break && clk_en |-> ##[1:4] debug_mode_q)
    else $error("debug break not taken");
endmodule // pipe_ctrl_checker

bind pipe_hazard_ctrl pipe_ctrl_checker chk_i (.mclk, .reset_n, .clk_en, .debug_break, .dreg_req, .dreg_sel,
  .fetch_en_q, .fetch_discard_q, .align_refetch_q, .id_stall_q, .id_phase2_q, .redirect_q, .redirect_pc_q,
  .debug_mode_q, .dcache_freeze_q, .dreg_grant_q, .dreg_deny_q);

// ===== tb/mem_model.sv
// Instruction ROM and data RAM model at the far side
`timescale 1ns/10ps
`include "pipe_ctrl_regs.vh"
module mem_model (
  input  wire         mclk,
  input  wire         fetch_en_q,
  input  wire         dmem_req_q,
  output logic        if_valid,
  output logic [3:0]  if_cls,
  output logic [4:0]  if_src1,
  output logic [4:0]  if_src2,
  output logic [4:0]  if_dst,
  output logic [4:0]  if_sreg,
  output logic [15:0] if_code,
  output logic        if_len4,
  output logic        if_mem_access,
  output integer      ram_hits
);
  // Nothing offered at time zero
  initial begin
    {if_valid, if_cls, if_src1, if_src2, if_dst, if_sreg, if_code, if_len4, if_mem_access} = '0;
    ram_hits = 0;
  end
  // RAM never waits
  // Data accesses answered at once, whatever fetch does
  always @(posedge mclk) if (dmem_req_q === 1'b1) ram_hits <= ram_hits + 1;
  // Offer at the falling edge, hold until fetch is open
  task automatic offer(input logic [3:0] c, input logic [4:0] s1, d, sr, input logic [15:0] cd, input logic l4);
    int n;
    begin
      n = 0;
      @(negedge mclk);
      {if_cls, if_src1, if_dst, if_sreg, if_code, if_len4} = {c, s1, d, sr, cd, l4};
      if_src2 = 5'h00;
      if_mem_access = (c == `CLS_LOAD);
      if_valid = 1'b1;
      while (fetch_en_q !== 1'b1 && n < 50) begin
        @(negedge mclk);
        n++;
      end
      @(posedge mclk);
    end
  endtask
  // Released fields flip so a stale word never looks valid
  task automatic rest();
    begin
      if_valid <= 1'b0;
      {if_cls, if_src1, if_dst, if_sreg, if_code} <= ~{if_cls, if_src1, if_dst, if_sreg, if_code};
    end
  endtask
endmodule // mem_model

// ===== tb/pipe_hazard_ctrl_bench.sv
// Self-checking bench for the pipeline hazard control
`timescale 1ns/10ps
`include "pipe_ctrl_regs.vh"
`define chk(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; $display("ERROR %0t got %h exp %h", $time, g, e); end end
module pipe_hazard_ctrl_bench;
  logic        mclk, reset_n, clk_en, id_br_taken, single_step_cfg, debug_break, dreg_req, dreg_write;
  logic [1:0]  dreg_sel;
  logic [31:0] id_br_target, debug_pc_save_reg, last_pc;
  wire         if_valid, if_len4, if_mem_access, fetch_en_q, fetch_discard_q, align_refetch_q, id_stall_q;
  wire         id_phase2_q, dmem_req_q, redirect_q, debug_mode_q, dcache_freeze_q, dreg_grant_q, dreg_deny_q;
  wire  [3:0]  if_cls;
  wire  [4:0]  if_src1, if_src2, if_dst, if_sreg;
  wire  [15:0] if_code;
  wire  [1:0]  fwd_src1_q, fwd_src2_q;
  wire  [31:0] redirect_pc_q, ram_hits;
  integer      error_cnt = 0, checked = 0, cyc = 0, n_al = 0, t0, na0, i;
  int          cnt [0:4];                // Pulses: discard, phase2, redirect, align, stall
  int          d [0:2];                  // Branch-to-next spacing per target
  logic [1:0]  fw_first;                 // Forward select just after a take
  // Pair of instructions and the interlock they should give
  typedef struct {logic [3:0] ca; logic [4:0] sa; logic [3:0] cb; logic [4:0] s1; logic [4:0] sb; int st;
    logic [1:0] fw;} row_t;
  row_t rows [0:6] = '{
    '{`CLS_ALU, 5'h00, `CLS_ALU, 5'h05, 5'h00, 0, `FWD_EX},
    '{`CLS_LOAD, 5'h00, `CLS_ALU, 5'h05, 5'h00, 1, `FWD_MEM},
    '{`CLS_HALFWORD_MULTIPLY_INSTR, 5'h00, `CLS_ALU, 5'h05, 5'h00, 1, `FWD_EX2},
    '{`CLS_LOAD, 5'h00, `CLS_ALU, 5'h06, 5'h00, 0, `FWD_RF},
    '{`CLS_SYSW, `SREG_IRQ_PC, `CLS_SYSR, 5'h00, `SREG_IRQ_PC, 2, `FWD_RF},
    '{`CLS_SYSW, `SREG_FATAL_PC, `CLS_SYSR, 5'h00, `SREG_FATAL_PC, 2, `FWD_RF},
    '{`CLS_SYSW, `SREG_IRQ_PC, `CLS_SYSR, 5'h00, `SREG_FATAL_PC, 0, `FWD_RF}};
  // Register access: group, write, granted
  logic [3:0]  acc [0:4] = '{4'ha, 4'h8, 4'h3, 4'h5, 4'h6};

  pipe_hazard_ctrl DUT (.mclk, .reset_n, .clk_en, .if_valid, .if_cls, .if_src1, .if_src2, .if_dst, .if_sreg,
    .if_code, .if_len4, .if_mem_access, .id_br_taken, .id_br_target, .debug_pc_save_reg, .single_step_cfg,
    .debug_break, .dreg_req, .dreg_write, .dreg_sel, .fetch_en_q, .fetch_discard_q, .align_refetch_q, .id_stall_q,
    .id_phase2_q, .fwd_src1_q, .fwd_src2_q, .dmem_req_q, .redirect_q, .redirect_pc_q, .debug_mode_q,
    .dcache_freeze_q, .dreg_grant_q, .dreg_deny_q);
  mem_model mem (.mclk, .fetch_en_q, .dmem_req_q, .if_valid, .if_cls, .if_src1, .if_src2, .if_dst, .if_sreg,
    .if_code, .if_len4, .if_mem_access, .ram_hits);

  // 50 MHz core clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // Cycle and refetch counters, read only between edges
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (align_refetch_q === 1'b1) n_al <= n_al + 1;
  end
  // Count pulses over n falling edges
  task automatic watch(input int n);
    logic [4:0] p;
    begin
      cnt = '{default: 0};
      for (int k = 0; k < n; k++) begin
        @(negedge mclk);
        p = {id_stall_q, align_refetch_q, redirect_q, id_phase2_q, fetch_discard_q};
        if (k == 0) fw_first = fwd_src1_q;
        if (redirect_q === 1'b1) last_pc = redirect_pc_q;
        for (int j = 0; j < 5; j++) cnt[j] += (p[j] === 1'b1);
      end
    end
  endtask
  // One lone instruction, then let it drain
  task automatic op(input logic [3:0] c, input logic [15:0] cd);
    begin
      mem.offer(c, 5'h00, 5'h00, 5'h00, cd, 1'b0);
      mem.rest();
      watch(8);
    end
  endtask
  // Debug register access, answer one edge later
  task automatic dreg(input logic [1:0] s, input logic w, input logic g);
    begin
      @(negedge mclk);
      {dreg_req, dreg_write, dreg_sel} = {1'b1, w, s};
      @(negedge mclk);
      dreg_req = 1'b0;
      `chk({dreg_grant_q, dreg_deny_q}, {g, ~g})
    end
  endtask
  // Verdict and end of run
  task results;
    begin
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  // Hang guard, far beyond the few hundred cycles used
  initial begin
    #100us;
    error_cnt++;
    results();
  end

  initial begin
    {reset_n, clk_en, id_br_taken, single_step_cfg, debug_break, dreg_req, dreg_write} = 7'h20;
    dreg_sel = 2'h0;
    id_br_target = 32'h0;
    debug_pc_save_reg = 32'h0000_2002;
    last_pc = 32'h0;
    repeat (20) @(negedge mclk);
    `chk({fetch_en_q, redirect_q, debug_mode_q}, 3'h0)
    reset_n = 1'b1;
    @(negedge mclk);
    `chk(fetch_en_q, 1'b1)
    // Dependent and independent pairs from the table
    foreach (rows[r]) begin
      mem.offer(rows[r].ca, 5'h00, 5'h05, rows[r].sa, 16'h0000, 1'b0);
      mem.offer(rows[r].cb, rows[r].s1, 5'h07, rows[r].sb, 16'h0000, 1'b0);
      mem.rest();
      watch(6);
      `chk(fw_first, rows[r].fw)
      `chk(cnt[4], rows[r].st)
    end
    `chk(ram_hits != 0, 1'b1)
    // Independent instructions go one per clock
    t0 = cyc;
    for (i = 0; i < 4; i++) mem.offer(`CLS_ALU, 5'h00, 5'(i + 8), 5'h00, 16'h0000, 1'b0);
    `chk(cyc - t0, 4)
    mem.rest();
    watch(4);
    op(`CLS_TRAP, 16'h0045);
    `chk({cnt[0], cnt[1]}, {32'd2, 32'd1})
    `chk({last_pc, debug_mode_q}, {32'h0000_0040, 1'b0})
    op(`CLS_DEBUG_TRAP_INSTR, `DBG_TRAP_CODE);
    `chk({cnt[0], cnt[1]}, {32'd2, 32'd1})
    `chk({last_pc, debug_mode_q, dcache_freeze_q}, {`DBG_HANDLER_ADDR, 2'h3})
    dreg(`DSEL_BREAK, 1'b1, 1'b1);
    op(`CLS_DEBUG_RETURN_INSTR, 16'h0000);
    `chk({last_pc, debug_mode_q, cnt[0]}, {debug_pc_save_reg, 1'b0, 32'd2})
    foreach (acc[k]) dreg(acc[k][3:2], acc[k][1], acc[k][0]);
    // Other ways into debug, each left by a return
    for (i = 0; i < 3; i++) begin
      if (i == 0) op(`CLS_INVALID, 16'h0000);
      if (i == 1) begin
        debug_break = 1'b1;
        watch(1);
        debug_break = 1'b0;
        watch(6);
      end
      if (i == 2) begin
        single_step_cfg = 1'b1;
        op(`CLS_ALU, 16'h0000);
        single_step_cfg = 1'b0;
      end
      `chk({debug_mode_q, last_pc}, {1'b1, `DBG_HANDLER_ADDR})
      op(`CLS_DEBUG_RETURN_INSTR, 16'h0000);
    end
    // Word-aligned target first, then the halfword-offset one
    for (i = 0; i < 2; i++) begin
      id_br_taken = 1'b1;
      id_br_target = i ? 32'h0000_0102 : 32'h0000_0104;
      t0 = cyc;
      na0 = n_al;
      mem.offer(`CLS_BRANCH, 5'h00, 5'h00, 5'h00, 16'h0000, 1'b0);
      mem.rest();
      // Target word is fetched only once the redirect has gone out
      watch(2);
      mem.offer(`CLS_ALU, 5'h00, 5'h00, 5'h00, 16'h0000, 1'b1);
      mem.offer(`CLS_ALU, 5'h00, 5'h00, 5'h00, 16'h0000, 1'b0);
      d[i] = cyc - t0;
      mem.rest();
      watch(8);
      id_br_taken = 1'b0;
      `chk(n_al - na0, i)
    end
    `chk(d[1] - d[0], 2)
    results();
  end
endmodule // pipe_hazard_ctrl_bench
